// [shared/interrupt_source_prioritizer_pkg.sv]
package interrupt_source_prioritizer_pkg;

    // Request presented to the processor core.
    typedef struct packed {
        logic irq;
        logic [7:0] vector;
        logic [2:0] line;
    } core_req_s;

    // Whole state of the prioritizer.
    typedef struct packed {
        logic [7:0] mask;
        logic [5:0] pend;
        logic [5:0] src_cfg;
        logic [1:0] pin_prev;
        logic primed;
        core_req_s core;
        logic [31:0] rdata;
        logic ready;
        logic slverr;
    } state_s;

endpackage : interrupt_source_prioritizer_pkg

// [shared/interrupt_source_prioritizer_regs.svh]
`ifndef INTERRUPT_SOURCE_PRIORITIZER_REGS_SVH
`define INTERRUPT_SOURCE_PRIORITIZER_REGS_SVH

// Register indexes; the byte address on the bus is four times the index.
`define PEND_IDX 10'h0FA
`define MASK_IDX 10'h0FB
`define SRC_CFG_IDX 10'h0F9
`define STATUS_IDX 10'h0F8
`define IDX_TO_ADDR(i) ({(i), 2'b00})

// Field positions and widths.
`define MASTER_BIT 7
`define LINE_COUNT 6
`define STATUS_IRQ_BIT 7

// Reset values.
`define MASK_RST 8'h00
`define PEND_RST 6'h00
`define SRC_CFG_RST 6'h00

// Writable bits; bit 6 of the mask and bits 6 and 7 of the pending register are reserved.
`define MASK_WMASK 8'hBF
`define PEND_WMASK 6'h3F
// Lines whose sources always set their pending bit; the others need their source enable bit.
`define SRC_ALWAYS 6'h25
`define SRC_CFG_WMASK 6'h1A

// Low byte of each two-byte vector location.
`define VEC_LINE0 8'h02
`define VEC_LINE1 8'h04
`define VEC_LINE2 8'h06
`define VEC_LINE3 8'h08
`define VEC_LINE4 8'h0A
`define VEC_LINE5 8'h0C
`define VEC_NONE 8'h00

`endif

// [sim/core_model.sv]
module core_model import interrupt_source_prioritizer_pkg::*; (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Request in, entry out.
    input wire core_req_s core_req,
    input wire logic ack_en,
    output logic irq_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    // Enters service for one cycle once a request is seen and entry is allowed.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_ack <= 1'b0;
        end else begin
            irq_ack <= ack_en && core_req.irq && !irq_ack;
        end
    end
endmodule : core_model

// [sim/interrupt_source_prioritizer_tb.sv]
module interrupt_source_prioritizer_tb import interrupt_source_prioritizer_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, port_b_pin_four, port_b_pin_two, interrupt_return_instruction;
    logic pready, pslverr, irq_ack, ack_en, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0] timer_timeout;
    core_req_s core_req;
    int err_count = 0;
    int cmp_count = 0;
    interrupt_source_prioritizer uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timer_timeout(timer_timeout), .port_b_pin_four(port_b_pin_four), .port_b_pin_two(port_b_pin_two),
        .irq_ack(irq_ack), .interrupt_return_instruction(interrupt_return_instruction), .core_req(core_req));
    core_model core (.pclk(pclk), .presetn(presetn), .core_req(core_req), .ack_en(ack_en), .irq_ack(irq_ack));
    // Free-running clock.
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // Compares one value and counts it.
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One bus transfer, held until ready, then one idle cycle.
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n == 16) begin
            err_count++;
            $display("[ERR] %0t no ready from the register port", $time);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    // Reads a register and compares it.
    task rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rdc
    // Waits a bounded time for the request level.
    task wait_irq(input logic v);
        int n;
        n = 0;
        while (core_req.irq !== v && n < 50) begin
            @(posedge pclk);
            n++;
        end
        chk(core_req.irq, v);
    endtask : wait_irq
    // Reset values of mask and pending registers.
    task t_reset;
        rdc(12'h3EC, 32'h0);
        rdc(12'h3E8, 32'h0);
        chk(core_req.irq, 1'b0);
    endtask : t_reset
    // All three time-outs at once, served in priority order.
    task t_timers;
        logic [10:0] exp_t [3] = '{11'h002, 11'h206, 11'h50C};
        apb(1'b1, 12'h3EC, 32'hA5);
        timer_timeout <= 3'h7;
        @(posedge pclk);
        timer_timeout <= 3'h0;
        wait_irq(1'b1);
        rdc(12'h3E8, 32'h25);
        ack_en <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            wait_irq(1'b1);
            chk({core_req.line, core_req.vector}, exp_t[i]);
            wait_irq(1'b0);
            interrupt_return_instruction <= 1'b1;
            @(posedge pclk);
            interrupt_return_instruction <= 1'b0;
        end
        ack_en <= 1'b0;
        rdc(12'h3E8, 32'h0);
    endtask : t_timers
    // Pin edges, first unconfigured, then with the edge enables set.
    task t_pins;
        apb(1'b1, 12'h3EC, 32'h9A);
        port_b_pin_two <= 1'b0;
        repeat (6) @(posedge pclk);
        rdc(12'h3E8, 32'h0);
        apb(1'b1, 12'h3E4, 32'h1A);
        port_b_pin_two <= 1'b1;
        repeat (6) @(posedge pclk);
        port_b_pin_four <= 1'b0;
        port_b_pin_two <= 1'b0;
        repeat (6) @(posedge pclk);
        port_b_pin_four <= 1'b1;
        repeat (6) @(posedge pclk);
        rdc(12'h3E8, 32'h1A);
        chk({core_req.line, core_req.vector}, 32'h104);
        rdc(12'h3E0, 32'h81);
        rdc(12'h3E4, 32'h1A);
        apb(1'b1, 12'h3E8, 32'h0);
    endtask : t_pins
    // Master gating, reserved bits, write against a source event, unmapped access.
    task t_collide;
        apb(1'b1, 12'h3EC, 32'h01);
        apb(1'b1, 12'h3E8, 32'hFF);
        repeat (2) @(posedge pclk);
        chk(core_req.irq, 1'b0);
        rdc(12'h3E8, 32'h3F);
        apb(1'b1, 12'h3EC, 32'h81);
        wait_irq(1'b1);
        fork
            apb(1'b1, 12'h3E8, 32'h0);
            begin
                @(posedge pclk);
                timer_timeout <= 3'h4;
                @(posedge pclk);
                timer_timeout <= 3'h0;
            end
        join
        rdc(12'h3E8, 32'h0);
        wait_irq(1'b0);
        apb(1'b0, 12'h100, 32'h0);
        chk(er, 1'b1);
        chk(rd, 32'h0);
    endtask : t_collide
    // Prints the counts and the verdict, then stops.
    task end_sim;
        $display("errors %0d checks %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim
    // Main sequence.
    initial begin
        {presetn, psel, penable, pwrite, ack_en, interrupt_return_instruction} = '0;
        {port_b_pin_four, port_b_pin_two} = 2'b11;
        paddr = 12'h0;
        pwdata = 32'h0;
        timer_timeout = 3'h0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset;
        t_timers;
        t_pins;
        t_collide;
        // Second reset in mid-run with mask and pending registers loaded.
        apb(1'b1, 12'h3EC, 32'h81);
        apb(1'b1, 12'h3E8, 32'h3F);
        wait_irq(1'b1);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset;
        rdc(12'h3E4, 32'h0);
        end_sim;
    end
    // Cuts a hang short.
    initial begin
        #100000;
        err_count++;
        $display("[ERR] %0t watchdog expired", $time);
        end_sim;
    end
endmodule : interrupt_source_prioritizer_tb

// [sim/prioritizer_monitor.sv]
module prioritizer_monitor import interrupt_source_prioritizer_pkg::*; (
    // Clock, reset and bus.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Core side.
    input wire logic irq_ack,
    input wire core_req_s core_req
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Bus answers in the cycle after setup and for that cycle only.
    a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no ready after setup");
    a_ready_one_cycle: assert property (pready |=> !pready) else $error("ready held too long");
    a_error_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
    a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0) else $error("read data not zero");
    // Vector and line of the presented request.
    a_vector_of_line: assert property (core_req.irq |-> core_req.vector == {4'h0, core_req.line, 1'b0} + 8'h02)
        else $error("vector does not match line");
    a_line_in_range: assert property (core_req.irq |-> core_req.line <= 3'h5) else $error("line out of range");
    a_vector_idle_zero: assert property (!core_req.irq |-> core_req.vector == 8'h00)
        else $error("vector without request");
    // Entry clears the master enable, so the request drops.
    a_ack_drops_irq: assert property (irq_ack && core_req.irq && !psel |=> !core_req.irq)
        else $error("request stayed after entry");
    c_entry: cover property (irq_ack && core_req.irq);
    c_last_line: cover property (core_req.irq && core_req.line == 3'h5);
    c_bus_error: cover property (pslverr);
endmodule : prioritizer_monitor

bind interrupt_source_prioritizer prioritizer_monitor mon (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_ack(irq_ack), .core_req(core_req));

// [verilog/interrupt_source_prioritizer.sv]
// Notes on behaviour
// - Timer zero, one and two time-outs set pending lines zero, two and five.
// - Falling edges on port B pins four and two set lines one and three.
// - Rising edge on port B pin four sets line four, apart from its fall.
// - Lines zero to five vector to locations 2, 4, 6, 8, A and C.
// - Fixed priority by line number, line zero highest, line five lowest.
// - Lines six and seven have no source and never become pending.
// - Timer sources always set their bit; pin edges only when enabled.
// - A source event sets the matching pending bit, bits zero to five.
// - Request recognised only with its mask bit and master enable set.
// - A software write to the pending register beats a same-cycle source event.
// - Reset clears mask and pending registers to zero.
//
// Decided for this implementation: the register offsets and register access over APB.
`include "interrupt_source_prioritizer_regs.svh"

module interrupt_source_prioritizer (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB register port.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Event sources.
    input wire logic [2:0] timer_timeout,
    input wire logic port_b_pin_four,
    input wire logic port_b_pin_two,
    // Processor core side.
    input wire logic irq_ack,
    input wire logic interrupt_return_instruction,
    output interrupt_source_prioritizer_pkg::core_req_s core_req
);
    import interrupt_source_prioritizer_pkg::*;

    state_s state_reg;
    state_s state_next;

    logic [`LINE_COUNT-1:0] src_event;
    logic [`LINE_COUNT-1:0] ack_clear;
    logic [`LINE_COUNT-1:0] enabled;
    logic [`LINE_COUNT-1:0] src_enable;
    logic setup_phase;
    logic access_phase;
    logic hit_pend;
    logic hit_mask;
    logic hit_cfg;
    logic hit_status;
    logic mapped;
    logic any_enabled;
    logic [2:0] win_line;
    logic [7:0] win_vector;

    // Edge detection on the two port B pins, valid once a first sample has been taken.
    logic fall_four;
    logic fall_two;
    logic rise_four;

    assign fall_four = state_reg.primed & state_reg.pin_prev[1] & ~port_b_pin_four;
    assign fall_two = state_reg.primed & state_reg.pin_prev[0] & ~port_b_pin_two;
    assign rise_four = state_reg.primed & ~state_reg.pin_prev[1] & port_b_pin_four;

    // Per-line source enable: timers are fixed on, pin edges follow the configuration.
    assign src_enable = `SRC_ALWAYS | (state_reg.src_cfg & `SRC_CFG_WMASK);

    // Map each source onto its request line.
    always_comb begin
        src_event = '0;
        src_event[0] = timer_timeout[0];
        src_event[1] = fall_four;
        src_event[2] = timer_timeout[1];
        src_event[3] = fall_two;
        src_event[4] = rise_four;
        src_event[5] = timer_timeout[2];
        src_event = src_event & src_enable;
    end

    // Address decode for the APB slave; only aligned words inside the map answer.
    assign setup_phase = psel & ~penable;
    assign access_phase = psel & penable & state_reg.ready;
    assign hit_pend = (paddr == `IDX_TO_ADDR(`PEND_IDX));
    assign hit_mask = (paddr == `IDX_TO_ADDR(`MASK_IDX));
    assign hit_cfg = (paddr == `IDX_TO_ADDR(`SRC_CFG_IDX));
    assign hit_status = (paddr == `IDX_TO_ADDR(`STATUS_IDX));
    assign mapped = hit_pend | hit_mask | hit_cfg | hit_status;

    // Acknowledge clears only the line that was being presented.
    always_comb begin
        ack_clear = '0;
        if (irq_ack && state_reg.core.irq) begin
            ack_clear[state_reg.core.line] = 1'b1;
        end
    end

    // Next state of registers and core request.
    always_comb begin
        state_next = state_reg;

        // Pin history for the edge detectors.
        state_next.pin_prev = {port_b_pin_four, port_b_pin_two};
        state_next.primed = 1'b1;

        // Source events set pending bits; acknowledge clears the winner. A set beats a clear.
        state_next.pend = (state_reg.pend & ~ack_clear) | src_event;

        // Master enable drops on entry and returns on the return instruction.
        if (irq_ack && state_reg.core.irq) begin
            state_next.mask[`MASTER_BIT] = 1'b0;
        end
        if (interrupt_return_instruction) begin
            state_next.mask[`MASTER_BIT] = 1'b1;
        end

        // A software write takes effect at the access edge and wins over hardware.
        if (access_phase && pwrite && mapped) begin
            if (hit_pend) begin
                state_next.pend = pwdata[`LINE_COUNT-1:0] & `PEND_WMASK;
            end
            if (hit_mask) begin
                state_next.mask = pwdata[7:0] & `MASK_WMASK;
            end
            if (hit_cfg) begin
                state_next.src_cfg = pwdata[`LINE_COUNT-1:0] & `SRC_CFG_WMASK;
            end
        end

        // Read data, ready and error are captured at the setup edge for the access phase.
        state_next.ready = setup_phase;
        state_next.slverr = setup_phase & ~mapped;
        state_next.rdata = '0;
        if (setup_phase && !pwrite) begin
            if (hit_pend) begin
                state_next.rdata[`LINE_COUNT-1:0] = state_reg.pend;
            end
            if (hit_mask) begin
                state_next.rdata[7:0] = state_reg.mask;
            end
            if (hit_cfg) begin
                state_next.rdata[`LINE_COUNT-1:0] = state_reg.src_cfg;
            end
            if (hit_status) begin
                state_next.rdata[`STATUS_IRQ_BIT] = state_reg.core.irq;
                state_next.rdata[2:0] = state_reg.core.line;
            end
        end

        // Lines that are pending, unmasked and globally enabled once this edge has passed.
        // Worked out inside this process so that no other process reads the next-state copy.
        enabled = state_next.pend & state_next.mask[`LINE_COUNT-1:0]
            & {`LINE_COUNT{state_next.mask[`MASTER_BIT]}};
        any_enabled = |enabled;

        // Fixed priority: scanning from the highest line down leaves the lowest index winning.
        win_line = '0;
        for (int i = `LINE_COUNT - 1; i >= 0; i--) begin
            if (enabled[i]) begin
                win_line = 3'(i);
            end
        end

        // Vector location for the winning line; no request shows the empty vector.
        case (win_line)
            3'h0: win_vector = `VEC_LINE0;
            3'h1: win_vector = `VEC_LINE1;
            3'h2: win_vector = `VEC_LINE2;
            3'h3: win_vector = `VEC_LINE3;
            3'h4: win_vector = `VEC_LINE4;
            3'h5: win_vector = `VEC_LINE5;
            default: win_vector = `VEC_NONE;
        endcase
        if (!any_enabled) begin
            win_vector = `VEC_NONE;
        end

        // Core request follows the registers as they will stand after this edge.
        state_next.core.irq = any_enabled;
        state_next.core.line = win_line;
        state_next.core.vector = win_vector;
    end

    // State register; reset clears mask and pending.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg.mask <= `MASK_RST;
            state_reg.pend <= `PEND_RST;
            state_reg.src_cfg <= `SRC_CFG_RST;
            state_reg.pin_prev <= 2'h0;
            state_reg.primed <= 1'b0;
            state_reg.core <= '0;
            state_reg.rdata <= 32'h0000_0000;
            state_reg.ready <= 1'b0;
            state_reg.slverr <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from the state register.
    assign prdata = state_reg.rdata;
    assign pready = state_reg.ready;
    assign pslverr = state_reg.slverr;
    assign core_req = state_reg.core;

endmodule : interrupt_source_prioritizer
